/* File: rtl/wdg_pkg.sv */
// package for the card watchdog: timing, channel width and status memory layout
// assumes a single 25 MHz system clock and an 8 kHz timer reference derived from it
package wdg_pkg;

	// ****************************************
	// timing
	// ****************************************
	localparam int CLOCK_PERIOD_NS = 40;
	localparam int REF_PERIOD_NS = 125000;
	localparam int TICK_CYCLES = REF_PERIOD_NS / CLOCK_PERIOD_NS;
	localparam int PRESCALE_W = 12;
	localparam logic [PRESCALE_W-1:0] PRESCALE_LAST = PRESCALE_W'(TICK_CYCLES - 1);
	localparam logic [PRESCALE_W-1:0] PRESCALE_RESET = 12'h000;

	// ****************************************
	// timer channel
	// ****************************************
	localparam int COUNT_W = 16;
	localparam logic [COUNT_W-1:0] COUNT_RESET = 16'h0000;
	localparam logic [COUNT_W-1:0] COUNT_LAST = 16'h0001;

	// ****************************************
	// battery-backed status memory
	// ****************************************
	localparam logic [7:0] STATUS_INDEX_BACKUP = 8'h0d;
	localparam int BACKUP_LOST_BIT = 7;
	localparam logic [7:0] STATUS_DATA_RESET = 8'h00;

	typedef enum logic [1:0]
	{
		WDG_IDLE = 2'b00,
		WDG_RUN = 2'b01,
		WDG_EXPIRED = 2'b10
	} wdg_state_e;

endpackage

/* File: rtl/wdg_timer_channel.sv */
// one down-counting interval timer channel with its output flip-flop
// assumes tick is a one-cycle pulse at the reference rate and load a one-cycle pulse
`timescale 1ns/10ps
`default_nettype none
module wdg_timer_channel
	import wdg_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// control
	input wire logic tick,
	input wire logic load,
	input wire logic run,
	input wire logic [COUNT_W-1:0] reload_value,
	// state
	output logic [COUNT_W-1:0] count,
	output logic channel_out
);

	// a reload value of zero wraps and so gives the longest period
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			count <= COUNT_RESET;
		else if (load)
			count <= reload_value;
		else if (run && tick && count != COUNT_RESET)
			count <= count - COUNT_LAST;
		else if (run && tick && channel_out)
			count <= count - COUNT_LAST;
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			channel_out <= 1'b1;
		else if (load || !run)
			channel_out <= 1'b1;
		else if (tick && count == COUNT_LAST)
			channel_out <= 1'b0;
	end

endmodule
`default_nettype wire

/* File: rtl/card_watchdog.sv */
// watchdog with active-low timeout pin and backup-power-lost status flag
// assumes RST_B is the board power-good signal and all inputs are synchronous to CLOCK
`timescale 1ns/10ps
`default_nettype none
module card_watchdog
	import wdg_pkg::*;
(
	// clock and power-good reset
	input wire logic CLOCK,
	input wire logic RST_B,
	// watchdog control
	input wire logic WDG_ARM,
	input wire logic WDG_RESTART,
	input wire logic [COUNT_W-1:0] WDG_PERIOD,
	// watchdog state
	output logic WATCHDOG_TIMEOUT_N,
	output logic [COUNT_W-1:0] WDG_COUNT,
	// backup supply status
	input wire logic BACKUP_SUPPLY_MISSING,
	input wire logic BACKUP_FLAG_CLEAR,
	input wire logic [7:0] STATUS_INDEX,
	output logic [7:0] STATUS_DATA
);

	// ****************************************
	// decode
	// ****************************************
	function automatic logic is_backup_index(input logic [7:0] index);
		is_backup_index = (index == STATUS_INDEX_BACKUP);
	endfunction

	// ****************************************
	// reference tick
	// ****************************************
	logic [PRESCALE_W-1:0] prescale;
	logic tick;

	// free-running so the reference phase does not depend on when software restarts
	always_ff @(posedge CLOCK or negedge RST_B)
	begin
		if (!RST_B)
			prescale <= PRESCALE_RESET;
		else if (prescale == PRESCALE_LAST)
			prescale <= PRESCALE_RESET;
		else
			prescale <= prescale + 12'h001;
	end

	assign tick = (prescale == PRESCALE_LAST);

	// ****************************************
	// sequencing
	// ****************************************
	wdg_state_e state;
	wdg_state_e next_state;
	logic load;
	logic run;
	logic timer_channel_output;

	always_comb
	begin
		next_state = state;
		case (state)
			WDG_IDLE:
			begin
				if (WDG_ARM)
					next_state = WDG_RUN;
			end
			WDG_RUN:
			begin
				if (!WDG_ARM)
					next_state = WDG_IDLE;
				else if (!WDG_RESTART && tick && WDG_COUNT == COUNT_LAST)
					next_state = WDG_EXPIRED;
			end
			WDG_EXPIRED:
			begin
				if (!WDG_ARM)
					next_state = WDG_IDLE;
				else if (WDG_RESTART)
					next_state = WDG_RUN;
			end
			default:
			begin
				next_state = WDG_IDLE;
			end
		endcase
	end

	always_ff @(posedge CLOCK or negedge RST_B)
	begin
		if (!RST_B)
			state <= WDG_IDLE;
		else
			state <= next_state;
	end

	// arming loads the period; a restart while armed reloads it in full
	assign load = WDG_ARM && (state == WDG_IDLE || WDG_RESTART);
	assign run = WDG_ARM && state != WDG_IDLE;

	wdg_timer_channel u_channel
	(
		.clk(CLOCK),
		.rst_b(RST_B),
		.tick(tick),
		.load(load),
		.run(run),
		.reload_value(WDG_PERIOD),
		.count(WDG_COUNT),
		.channel_out(timer_channel_output)
	);

	// no gating here: the pin follows the channel flip-flop exactly
	assign WATCHDOG_TIMEOUT_N = timer_channel_output;

	// ****************************************
	// backup supply status
	// ****************************************
	logic backup_lost;

	// set wins over clear so a loss seen in the clear cycle survives
	always_ff @(posedge CLOCK or negedge RST_B)
	begin
		if (!RST_B)
			backup_lost <= 1'b0;
		else if (BACKUP_SUPPLY_MISSING)
			backup_lost <= 1'b1;
		else if (BACKUP_FLAG_CLEAR)
			backup_lost <= 1'b0;
	end

	always_ff @(posedge CLOCK or negedge RST_B)
	begin
		if (!RST_B)
			STATUS_DATA <= STATUS_DATA_RESET;
		else if (is_backup_index(STATUS_INDEX))
			STATUS_DATA <= 8'(backup_lost) << BACKUP_LOST_BIT;
		else
			STATUS_DATA <= STATUS_DATA_RESET;
	end

	// ****************************************
	// checks
	// ****************************************
	logic [PRESCALE_W-1:0] tick_gap;
	logic tick_seen;

	always_ff @(posedge CLOCK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			tick_gap <= PRESCALE_RESET;
			tick_seen <= 1'b0;
		end
		else if (tick)
		begin
			tick_gap <= PRESCALE_RESET;
			tick_seen <= 1'b1;
		end
		else
			tick_gap <= tick_gap + 12'h001;
	end

	default clocking cb @(posedge CLOCK);
	endclocking
	default disable iff (!RST_B);

	sequence expiry_step;
		state == WDG_RUN && WDG_ARM && !WDG_RESTART && tick && WDG_COUNT == COUNT_LAST;
	endsequence

	sequence restart_step;
		WDG_ARM && WDG_RESTART && state != WDG_IDLE;
	endsequence

	chk_tick_spacing: assert property (
		tick && tick_seen |-> tick_gap == PRESCALE_LAST)
		else $error("reference tick spacing wrong");

	chk_pin_follows_channel: assert property (
		$fell(WATCHDOG_TIMEOUT_N) |-> $past(tick) && $past(WDG_COUNT) == COUNT_LAST)
		else $error("timeout pin lags the channel expiry");

	chk_expiry_drives_low: assert property (
		expiry_step |=> !WATCHDOG_TIMEOUT_N && state == WDG_EXPIRED)
		else $error("expiry did not pull the pin low");

	chk_running_pin_high: assert property (
		state == WDG_RUN |-> WATCHDOG_TIMEOUT_N)
		else $error("pin low while running");

	chk_low_holds: assert property (
		!WATCHDOG_TIMEOUT_N && WDG_ARM && !WDG_RESTART |=> !WATCHDOG_TIMEOUT_N)
		else $error("timeout pin released without restart");

	chk_disarm_release: assert property (
		!WDG_ARM |=> WATCHDOG_TIMEOUT_N)
		else $error("timeout pin held low while stopped");

	chk_restart_reload: assert property (
		restart_step |=> WATCHDOG_TIMEOUT_N && WDG_COUNT == $past(WDG_PERIOD))
		else $error("restart did not reload full period");

	chk_backup_flag_set: assert property (
		BACKUP_SUPPLY_MISSING |=> backup_lost ##1 (backup_lost || $past(BACKUP_FLAG_CLEAR)))
		else $error("backup loss not recorded");

	chk_backup_flag_read: assert property (
		is_backup_index(STATUS_INDEX) && backup_lost |=> STATUS_DATA[BACKUP_LOST_BIT])
		else $error("backup flag not visible at its index");

endmodule
`default_nettype wire

/* File: verif/wdg_recovery_board.sv */
// board model: routes the timeout pin to one recovery line, makes power good
// assumes the timeout pin is an active-low level and the route strap is static
`timescale 1ns/10ps
`default_nettype none
module wdg_recovery_board
(
	// from the block and the board
	input wire logic timeout_n,
	input wire logic [1:0] route,
	input wire logic backup_on_main,
	// irq, nmi, smi, reset lines, all active low
	output logic [3:0] recovery_n,
	output logic power_good
);
	// ****************
	// routing
	// ****************
	always_comb
	begin
		recovery_n = 4'hf;
		recovery_n[route] = timeout_n;
	end
	// held off while the backup still runs on the battery, else the clock memory may corrupt
	assign power_good = backup_on_main;
endmodule
`default_nettype wire

/* File: verif/card_watchdog_tb.sv */
// self-checking bench for the card watchdog
// assumes a 25 MHz clock and a tick every 3125 cycles; a period of 2 ticks keeps runs short
`timescale 1ns/10ps
`default_nettype none
module card_watchdog_tb;
	import wdg_pkg::*;
	logic CLOCK = 1'b0, rst_hold_b = 1'b0, backup_on_main = 1'b0;
	logic WDG_ARM = 1'b0, WDG_RESTART = 1'b0, BACKUP_SUPPLY_MISSING = 1'b0;
	logic BACKUP_FLAG_CLEAR = 1'b0;
	logic [COUNT_W-1:0] WDG_PERIOD = 16'h0002;
	logic [7:0] STATUS_INDEX = 8'h0d;
	logic [1:0] route = 2'h0;
	logic WATCHDOG_TIMEOUT_N, power_good, RST_B, low_seen;
	logic [COUNT_W-1:0] WDG_COUNT;
	logic [7:0] STATUS_DATA;
	logic [3:0] recovery_n;
	int err_total = 0, n_tests = 0, cnt;
	assign RST_B = rst_hold_b & power_good;
	card_watchdog dut (.CLOCK(CLOCK), .RST_B(RST_B), .WDG_ARM(WDG_ARM),
		.WDG_RESTART(WDG_RESTART), .WDG_PERIOD(WDG_PERIOD),
		.WATCHDOG_TIMEOUT_N(WATCHDOG_TIMEOUT_N), .WDG_COUNT(WDG_COUNT),
		.BACKUP_SUPPLY_MISSING(BACKUP_SUPPLY_MISSING), .BACKUP_FLAG_CLEAR(BACKUP_FLAG_CLEAR),
		.STATUS_INDEX(STATUS_INDEX), .STATUS_DATA(STATUS_DATA));
	wdg_recovery_board board (.timeout_n(WATCHDOG_TIMEOUT_N), .route(route),
		.backup_on_main(backup_on_main), .recovery_n(recovery_n), .power_good(power_good));
	// ****************
	// helpers
	// ****************
	initial
	begin
		forever #20 CLOCK = ~CLOCK;
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			err_total++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic finish_test;
		$display("errors=%0d checks=%0d", err_total, n_tests);
		if (err_total == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic pulse_restart;
		@(negedge CLOCK) WDG_RESTART = 1'b1;
		@(negedge CLOCK) WDG_RESTART = 1'b0;
	endtask
	// ****************
	// scenarios
	// ****************
	task automatic t_expire;
		@(negedge CLOCK) WDG_ARM = 1'b1;
		@(negedge CLOCK) chk(WDG_COUNT, 16'h0002);
		cnt = 1;
		while (WATCHDOG_TIMEOUT_N === 1'b1 && cnt < 8000)
		begin
			@(negedge CLOCK) cnt++;
		end
		chk(16'(cnt > 3125 && cnt <= 6252), 16'h0001);
		chk(WATCHDOG_TIMEOUT_N, 16'h0000);
		chk(WDG_COUNT, 16'h0000);
		for (int r = 0; r < 4; r++)
		begin
			@(negedge CLOCK) route = 2'(r);
			@(negedge CLOCK) chk(recovery_n, {12'h000, ~(4'h1 << r)});
		end
	endtask
	task automatic t_keepalive;
		pulse_restart();
		chk(WATCHDOG_TIMEOUT_N, 16'h0001);
		chk(WDG_COUNT, 16'h0002);
		low_seen = 1'b0;
		for (int i = 0; i < 4; i++)
		begin
			repeat (3000) @(negedge CLOCK) low_seen |= ~WATCHDOG_TIMEOUT_N;
			pulse_restart();
			chk(WDG_COUNT, 16'h0002);
		end
		chk(low_seen, 16'h0000);
	endtask
	task automatic t_disarm;
		cnt = 0;
		while (WATCHDOG_TIMEOUT_N === 1'b1 && cnt < 7000)
		begin
			@(negedge CLOCK) cnt++;
		end
		chk(WATCHDOG_TIMEOUT_N, 16'h0000);
		@(negedge CLOCK) WDG_ARM = 1'b0;
		@(negedge CLOCK) chk(WATCHDOG_TIMEOUT_N, 16'h0001);
		pulse_restart();
		chk(WDG_COUNT, 16'h0000);
		low_seen = 1'b0;
		repeat (7000) @(negedge CLOCK) low_seen |= ~WATCHDOG_TIMEOUT_N;
		chk(low_seen, 16'h0000);
	endtask
	task automatic t_backup;
		chk(STATUS_DATA, 16'h0000);
		@(negedge CLOCK) BACKUP_SUPPLY_MISSING = 1'b1;
		@(negedge CLOCK) BACKUP_SUPPLY_MISSING = 1'b0;
		@(negedge CLOCK) chk(STATUS_DATA, 16'h0080);
		STATUS_INDEX = 8'h0e;
		@(negedge CLOCK) chk(STATUS_DATA, 16'h0000);
		STATUS_INDEX = 8'h0d;
		BACKUP_FLAG_CLEAR = 1'b1;
		@(negedge CLOCK) BACKUP_FLAG_CLEAR = 1'b0;
		@(negedge CLOCK) chk(STATUS_DATA, 16'h0000);
		BACKUP_FLAG_CLEAR = 1'b1;
		BACKUP_SUPPLY_MISSING = 1'b1;
		@(negedge CLOCK) BACKUP_FLAG_CLEAR = 1'b0;
		BACKUP_SUPPLY_MISSING = 1'b0;
		@(negedge CLOCK) chk(STATUS_DATA, 16'h0080);
	endtask
	initial
	begin
		repeat (50000) @(posedge CLOCK);
		err_total++;
		finish_test();
	end
	initial
	begin
		repeat (2) @(negedge CLOCK);
		backup_on_main = 1'b1;
		@(negedge CLOCK) rst_hold_b = 1'b1;
		@(negedge CLOCK) chk(WATCHDOG_TIMEOUT_N, 16'h0001);
		chk(WDG_COUNT, 16'h0000);
		t_backup();
		t_expire();
		t_keepalive();
		t_disarm();
		finish_test();
	end
endmodule
`default_nettype wire
